// *** src/sdm_driver.sv ***
// step and direction microstep driver logic with Avalon-MM register slave
// Operation
// - one microstep per accepted step rising edge
// - resolution low 1/8, high 1/256
// - direction low clockwise, high counter-clockwise
// - enable low removes current, high energizes
// - resolution taken only while enable low
// - boost high raises current above nominal
// - standstill lowers current to two thirds
// - overtemperature or supply fault latches shutdown
// - restart needs enable rise after fault clears
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`default_nettype none
module sdm_driver #(
   parameter int unsigned STANDSTILL_CYCLES = sdm_pkg::STANDSTILL_CYC
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // motion inputs
   input wire logic step_i,
   input wire logic dir_i,
   input wire logic res_sel_i,
   input wire logic enable_i,
   input wire logic boost_i,
   // protection comparators
   input wire logic over_temp_i,
   input wire logic supply_fault_i,
   // power stage
   output logic drv_en_o,
   output logic [1:0] cur_level_o,
   output logic [sdm_pkg::PHASE_W-1:0] phase_o,
   output logic fault_o,
   // avalon-mm slave
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // interrupt
   output logic irq_o
);
   sdm_pkg::sdm_state_e state_q, state_d;
   logic step_rise, en_rise, en_level;
   logic fault_cond, run, step_take, step_ignored;
   logic idle, idle_q;
   logic res_q, dir_lvl;
   logic [31:0] pos_q;
   logic [sdm_pkg::PHASE_W-1:0] phase_q, phase_inc;
   logic [1:0] cur_d, cur_q;
   logic drv_q, fault_q;
   logic [31:0] ctrl_q;
   logic [sdm_pkg::IRQ_W-1:0] ists_q, ists_d, ien_q, irq_events, irq_clr;
   logic irq_q;
   logic wait_q;
   logic [31:0] rdata_q, rdata_d, status_w;
   logic bus_req, bus_done, wr_done;

   sdm_edge u_step_edge (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .sig_i(step_i),
      .level_o(),
      .rise_o(step_rise)
   );

   sdm_edge u_en_edge (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .sig_i(enable_i),
      .level_o(en_level),
      .rise_o(en_rise)
   );

   sdm_idle_timer #(
      .CYCLES(STANDSTILL_CYCLES)
   ) u_idle (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .active_i(run),
      .kick_i(step_take),
      .idle_o(idle)
   );

   assign fault_cond = over_temp_i | supply_fault_i;
   assign run = (state_q == sdm_pkg::ST_RUN);
   assign step_take = step_rise & run;
   assign step_ignored = step_rise & ~run;
   assign dir_lvl = dir_i;
   assign phase_inc = res_q ? sdm_pkg::PHASE_INC_FINE : sdm_pkg::PHASE_INC_COARSE;

   // drive state
   always_comb begin
      state_d = state_q;
      case (state_q)
         sdm_pkg::ST_OFF: begin
            if (fault_cond) begin
               state_d = sdm_pkg::ST_FAULT;
            end else if (enable_i) begin
               state_d = sdm_pkg::ST_RUN;
            end
         end
         sdm_pkg::ST_RUN: begin
            if (fault_cond) begin
               state_d = sdm_pkg::ST_FAULT;
            end else if (!enable_i) begin
               state_d = sdm_pkg::ST_OFF;
            end
         end
         sdm_pkg::ST_FAULT: begin
            if (!fault_cond && en_rise) begin
               state_d = sdm_pkg::ST_RUN;
            end
         end
         default: begin
            state_d = sdm_pkg::ST_FAULT;
         end
      endcase
   end

   // current level: standstill reduction wins over boost since holding needs no extra torque
   always_comb begin
      if (state_d != sdm_pkg::ST_RUN) begin
         cur_d = sdm_pkg::CUR_OFF;
      end else if (idle && ctrl_q[sdm_pkg::CTRL_HOLD_REDUCE_BIT] && !step_take) begin
         cur_d = sdm_pkg::CUR_HOLD;
      end else if (boost_i) begin
         cur_d = sdm_pkg::CUR_BOOST;
      end else begin
         cur_d = sdm_pkg::CUR_NOM;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_q <= sdm_pkg::ST_OFF;
         drv_q <= 1'b0;
         fault_q <= 1'b0;
         cur_q <= sdm_pkg::CUR_OFF;
         idle_q <= 1'b0;
      end else begin
         state_q <= state_d;
         drv_q <= (state_d == sdm_pkg::ST_RUN);
         fault_q <= (state_d == sdm_pkg::ST_FAULT);
         cur_q <= cur_d;
         idle_q <= idle;
      end
   end

   // resolution follows pin only while disabled
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         res_q <= 1'b0;
      end else if (!enable_i) begin
         res_q <= res_sel_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         pos_q <= 32'h0000_0000;
         phase_q <= '0;
      end else if (step_take && !dir_lvl) begin
         pos_q <= pos_q + 32'h0000_0001;
         phase_q <= phase_q + phase_inc;
      end else if (step_take) begin
         pos_q <= pos_q - 32'h0000_0001;
         phase_q <= phase_q - phase_inc;
      end
   end

   // interrupts: hardware set wins over a software clear in the same cycle
   assign irq_events[sdm_pkg::IRQ_FAULT_BIT] = (state_d == sdm_pkg::ST_FAULT) & ~fault_q;
   assign irq_events[sdm_pkg::IRQ_IDLE_BIT] = idle & ~idle_q;
   assign irq_events[sdm_pkg::IRQ_IGNORED_BIT] = step_ignored;
   assign irq_clr = (wr_done && avs_address_i == sdm_pkg::OFF_IRQ_CLEAR) ?
      avs_writedata_i[sdm_pkg::IRQ_W-1:0] : '0;
   assign ists_d = (ists_q & ~irq_clr) | irq_events;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ists_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ists_q <= ists_d;
         irq_q <= |(ists_d & ien_q);
      end
   end

   // bus: one wait cycle, so every access completes on the second edge after it is raised
   assign bus_req = avs_read_i | avs_write_i;
   assign bus_done = bus_req & ~wait_q;
   assign wr_done = avs_write_i & ~wait_q;

   always_comb begin
      status_w = 32'h0000_0000;
      status_w[sdm_pkg::STS_ENABLE_BIT] = en_level;
      status_w[sdm_pkg::STS_FAULT_BIT] = fault_q;
      status_w[sdm_pkg::STS_RES_BIT] = res_q;
      status_w[sdm_pkg::STS_BOOST_BIT] = boost_i;
      status_w[sdm_pkg::STS_IDLE_BIT] = idle_q;
      status_w[sdm_pkg::STS_DRV_BIT] = drv_q;
      status_w[sdm_pkg::STS_CUR_LSB +: 2] = cur_q;
   end

   always_comb begin
      if (avs_address_i == sdm_pkg::OFF_CTRL) begin
         rdata_d = ctrl_q;
      end else if (avs_address_i == sdm_pkg::OFF_STATUS) begin
         rdata_d = status_w;
      end else if (avs_address_i == sdm_pkg::OFF_POSITION) begin
         rdata_d = pos_q;
      end else if (avs_address_i == sdm_pkg::OFF_IRQ_STATUS) begin
         rdata_d = {29'h0000_0000, ists_q};
      end else if (avs_address_i == sdm_pkg::OFF_IRQ_ENABLE) begin
         rdata_d = {29'h0000_0000, ien_q};
      end else begin
         rdata_d = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q <= ~(bus_req & wait_q);
         rdata_q <= (avs_read_i && wait_q) ? rdata_d : rdata_q;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ctrl_q <= sdm_pkg::CTRL_RESET;
         ien_q <= sdm_pkg::IRQ_EN_RESET;
      end else if (wr_done && avs_address_i == sdm_pkg::OFF_CTRL) begin
         ctrl_q <= {31'h0000_0000, avs_writedata_i[sdm_pkg::CTRL_HOLD_REDUCE_BIT]};
      end else if (wr_done && avs_address_i == sdm_pkg::OFF_IRQ_ENABLE) begin
         ien_q <= avs_writedata_i[sdm_pkg::IRQ_W-1:0];
      end
   end

   assign drv_en_o = drv_q;
   assign cur_level_o = cur_q;
   assign phase_o = phase_q;
   assign fault_o = fault_q;
   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign irq_o = irq_q;

   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_fault_hit;
      fault_cond;
   endsequence

   sequence s_shut_down;
      fault_q && !drv_q && (cur_q == sdm_pkg::CUR_OFF);
   endsequence

   a_step_one_usteps: assert property (step_take |=> (pos_q - $past(pos_q) == 32'h0000_0001) ||
      ($past(pos_q) - pos_q == 32'h0000_0001))
      else $error("accepted step did not move exactly one microstep");

   a_res_increment: assert property (step_take && !res_q && !dir_lvl |=>
      phase_q == $past(phase_q) + sdm_pkg::PHASE_INC_COARSE)
      else $error("coarse resolution phase increment wrong");

   a_dir_sense: assert property (step_take |=> (pos_q == $past(pos_q) + 32'h0000_0001) == !$past(dir_lvl))
      else $error("direction sense wrong");

   a_enable_power: assert property (!enable_i |=> !drv_q && cur_q == sdm_pkg::CUR_OFF)
      else $error("drive on while enable low");

   a_res_frozen: assert property (enable_i |=> $stable(res_q))
      else $error("resolution changed while enabled");

   a_boost_current: assert property (run && enable_i && !fault_cond && boost_i && !idle |=>
      cur_q == sdm_pkg::CUR_BOOST)
      else $error("boost not applied");

   a_hold_current: assert property (run && enable_i && !fault_cond && idle && !step_take &&
      ctrl_q[sdm_pkg::CTRL_HOLD_REDUCE_BIT] |=> cur_q == sdm_pkg::CUR_HOLD)
      else $error("standstill current not reduced");

   a_fault_shutdown: assert property (s_fault_hit |=> s_shut_down)
      else $error("fault did not shut the driver off");

   a_fault_restart: assert property (fault_q && !(en_rise && !fault_cond) |=> fault_q && !drv_q)
      else $error("left fault without enable edge");

   a_step_ignored: assert property (step_rise && !run |=> $stable(pos_q) && $stable(phase_q))
      else $error("step moved motor while not running");

   a_idle_release: assert property (idle && step_take |=> !idle)
      else $error("step did not end standstill");

   a_bus_one_wait: assert property (bus_req && wait_q |=> !wait_q ##1 wait_q)
      else $error("bus answer timing wrong");
endmodule // sdm_driver
`default_nettype wire

// *** src/sdm_pkg.sv ***
// constants shared by the step and direction microstep driver logic
`default_nettype none
package sdm_pkg;
   // register byte offsets
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_STATUS = 5'h04;
   localparam logic [4:0] OFF_POSITION = 5'h08;
   localparam logic [4:0] OFF_IRQ_STATUS = 5'h0c;
   localparam logic [4:0] OFF_IRQ_CLEAR = 5'h10;
   localparam logic [4:0] OFF_IRQ_ENABLE = 5'h14;
   // control fields
   localparam int CTRL_HOLD_REDUCE_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   // status fields
   localparam int STS_ENABLE_BIT = 0;
   localparam int STS_FAULT_BIT = 1;
   localparam int STS_RES_BIT = 2;
   localparam int STS_BOOST_BIT = 3;
   localparam int STS_IDLE_BIT = 4;
   localparam int STS_DRV_BIT = 5;
   localparam int STS_CUR_LSB = 8;
   // interrupt bits
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_IDLE_BIT = 1;
   localparam int IRQ_IGNORED_BIT = 2;
   localparam int IRQ_W = 3;
   localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 3'h0;
   // winding current levels
   localparam logic [1:0] CUR_OFF = 2'h0;
   localparam logic [1:0] CUR_HOLD = 2'h1;
   localparam logic [1:0] CUR_NOM = 2'h2;
   localparam logic [1:0] CUR_BOOST = 2'h3;
   // phase grid: 256 microsteps per full step, four full steps per electrical turn
   localparam int PHASE_W = 10;
   localparam logic [PHASE_W-1:0] PHASE_INC_FINE = 10'h001;
   localparam logic [PHASE_W-1:0] PHASE_INC_COARSE = 10'h020;
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int STANDSTILL_US = 100000;
   localparam int STANDSTILL_CYC = (STANDSTILL_US * 1000) / CLK_PERIOD_NS;
   localparam int IDLE_CNT_W = 24;
   typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_FAULT} sdm_state_e;
endpackage // sdm_pkg
`default_nettype wire

// *** src/sdm_edge.sv ***
// registered copy of a synchronous input with rising edge detect
`default_nettype none
module sdm_edge (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // signal
   input wire logic sig_i,
   output logic level_o,
   output logic rise_o
);
   logic level_q;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         level_q <= 1'b0;
      end else begin
         level_q <= sig_i;
      end
   end

   assign level_o = level_q;
   assign rise_o = sig_i & ~level_q;
endmodule // sdm_edge
`default_nettype wire

// *** src/sdm_idle_timer.sv ***
// standstill timer: flags idle after a quiet period with no step
`default_nettype none
module sdm_idle_timer #(
   parameter int unsigned CYCLES = 2000000
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // control
   input wire logic active_i,
   input wire logic kick_i,
   output logic idle_o
);
   localparam int unsigned LAST_FULL = CYCLES - 1;
   localparam logic [sdm_pkg::IDLE_CNT_W-1:0] LAST = LAST_FULL[sdm_pkg::IDLE_CNT_W-1:0];
   logic [sdm_pkg::IDLE_CNT_W-1:0] cnt_q;
   logic idle_q;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !active_i || kick_i) begin
         cnt_q <= '0;
         idle_q <= 1'b0;
      end else if (cnt_q == LAST) begin
         idle_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign idle_o = idle_q;
endmodule // sdm_idle_timer
`default_nettype wire

// *** verification/sdm_ctrl_model.sv ***
// motion controller model: bursts of step pulses with direction
`default_nettype none
module sdm_ctrl_model (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // burst request
   input wire logic start_i,
   input wire logic dir_i,
   input wire logic [7:0] n_i,
   input wire logic [7:0] half_i,
   // pins
   output logic step_o,
   output logic dir_o,
   output logic busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] edges_q;
   logic [7:0] tmr_q;
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         step_o <= 1'b0;
         dir_o <= 1'b0;
         busy_o <= 1'b0;
         edges_q <= 9'h0;
         tmr_q <= 8'h0;
      end else if (!busy_o) begin
         // dir settles a whole low phase before the first rise
         if (start_i) begin
            busy_o <= 1'b1;
            dir_o <= dir_i;
            edges_q <= {n_i, 1'b0};
            tmr_q <= half_i;
         end
      end else if (tmr_q != 8'h0) begin
         tmr_q <= tmr_q - 8'h1;
      end else if (edges_q == 9'h0) begin
         busy_o <= 1'b0;
      end else begin
         step_o <= ~step_o;
         edges_q <= edges_q - 9'h1;
         tmr_q <= half_i;
      end
   end
endmodule // sdm_ctrl_model
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the microstep driver
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   // short standstill so a test does not wait 100 ms
   localparam int unsigned STB = 200;
   logic clk_sys_i, sys_rst_i, res_sel_i, enable_i, boost_i, over_temp_i, supply_fault_i;
   logic rd, wr, wt, irq, drv_en, fault, start, mdir, busy;
   logic [4:0] ad;
   logic [31:0] wd, rdata, q;
   logic [1:0] cur;
   logic [9:0] ph;
   logic [7:0] mn, mh;
   wire logic step, dir;
   int fails, samples_checked, cycles;
   sdm_ctrl_model ctl (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .start_i(start), .dir_i(mdir),
      .n_i(mn), .half_i(mh), .step_o(step), .dir_o(dir), .busy_o(busy));
   sdm_driver #(.STANDSTILL_CYCLES(STB)) dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .step_i(step), .dir_i(dir), .res_sel_i(res_sel_i), .enable_i(enable_i), .boost_i(boost_i),
      .over_temp_i(over_temp_i), .supply_fault_i(supply_fault_i), .drv_en_o(drv_en),
      .cur_level_o(cur), .phase_o(ph), .fault_o(fault), .avs_address_i(ad), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
      .irq_o(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // sampled waitrequest and readdata are the values before this edge
   // no local limit: only the hang guard ends a wait
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      rd <= ~w;
      wr <= w;
      ad <= a;
      wd <= d;
      do begin
         @(posedge clk_sys_i);
      end while (wt !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic steps(input logic d, input logic [7:0] k, input logic [7:0] h);
      mdir <= d;
      mn <= k;
      mh <= h;
      start <= 1'b1;
      @(posedge clk_sys_i);
      start <= 1'b0;
      do begin
         @(posedge clk_sys_i);
      end while (busy !== 1'b0);
   endtask
   task automatic t_reset;
      chk({drv_en, cur, ph, fault, irq, wt}, {1'b0, 2'h0, 10'h000, 1'b0, 1'b0, 1'b1});
      rchk(sdm_pkg::OFF_CTRL, 32'h1);
      rchk(sdm_pkg::OFF_IRQ_ENABLE, 32'h0);
      rchk(5'h1c, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_run;
      res_sel_i <= 1'b0;
      enable_i <= 1'b1;
      cyc(3);
      chk({drv_en, cur}, {1'b1, sdm_pkg::CUR_NOM});
      steps(1'b0, 8'h3, 8'd50);
      chk(ph, 10'h060);
      rchk(sdm_pkg::OFF_POSITION, 32'h3);
      res_sel_i <= 1'b1;
      steps(1'b1, 8'h2, 8'd90);
      chk(ph, 10'h020);
      enable_i <= 1'b0;
      cyc(3);
      chk({drv_en, cur}, {1'b0, sdm_pkg::CUR_OFF});
      enable_i <= 1'b1;
      cyc(3);
      steps(1'b1, 8'h1, 8'd50);
      chk(ph, 10'h01f);
      rchk(sdm_pkg::OFF_POSITION, 32'h0);
      $display("run test done");
   endtask
   task automatic t_boost;
      steps(1'b0, 8'h1, 8'd49);
      boost_i <= 1'b1;
      cyc(3);
      chk(cur, sdm_pkg::CUR_BOOST);
      boost_i <= 1'b0;
      cyc(3);
      chk(cur, sdm_pkg::CUR_NOM);
      $display("boost test done");
   endtask
   task automatic t_idle;
      cyc(STB + 10);
      chk(cur, sdm_pkg::CUR_HOLD);
      steps(1'b0, 8'h1, 8'd50);
      chk({cur, ph}, {sdm_pkg::CUR_NOM, 10'h021});
      rchk(sdm_pkg::OFF_IRQ_STATUS, 32'h2);
      bus(1'b1, sdm_pkg::OFF_IRQ_ENABLE, 32'h0);
      cyc(2);
      chk(irq, 1'b0);
      bus(1'b1, sdm_pkg::OFF_IRQ_ENABLE, 32'h2);
      cyc(2);
      chk(irq, 1'b1);
      bus(1'b1, sdm_pkg::OFF_IRQ_CLEAR, 32'h2);
      cyc(2);
      chk(irq, 1'b0);
      rchk(sdm_pkg::OFF_IRQ_STATUS, 32'h0);
      $display("standstill test done");
   endtask
   task automatic t_fault;
      over_temp_i <= 1'b1;
      cyc(3);
      chk({fault, drv_en, cur}, {1'b1, 1'b0, sdm_pkg::CUR_OFF});
      steps(1'b0, 8'h2, 8'd50);
      chk(ph, 10'h021);
      bus(1'b0, sdm_pkg::OFF_IRQ_STATUS, 32'h0);
      chk(q & 32'h5, 32'h5);
      over_temp_i <= 1'b0;
      cyc(3);
      chk(fault, 1'b1);
      enable_i <= 1'b0;
      cyc(2);
      enable_i <= 1'b1;
      cyc(3);
      chk({fault, drv_en}, 2'b01);
      supply_fault_i <= 1'b1;
      cyc(3);
      chk({fault, drv_en}, 2'b10);
      supply_fault_i <= 1'b0;
      enable_i <= 1'b0;
      cyc(2);
      enable_i <= 1'b1;
      cyc(3);
      chk({fault, drv_en}, 2'b01);
      $display("fault test done");
   endtask
   // hold reduction switched off by software, then back on at standstill
   task automatic t_hold;
      bus(1'b1, sdm_pkg::OFF_CTRL, 32'h0);
      rchk(sdm_pkg::OFF_CTRL, 32'h0);
      cyc(STB + 10);
      chk(cur, sdm_pkg::CUR_NOM);
      rchk(sdm_pkg::OFF_STATUS, 32'h235);
      bus(1'b1, sdm_pkg::OFF_CTRL, 32'h1);
      cyc(2);
      chk(cur, sdm_pkg::CUR_HOLD);
      $display("hold control test done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // hang guard, the tests need just over two thousand cycles
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   initial begin
      {sys_rst_i, res_sel_i, enable_i, boost_i, over_temp_i, supply_fault_i} = 6'b100000;
      {rd, wr, start, mdir, ad, wd, mn, mh} = '0;
      fails = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (3) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_sys_i);
      t_reset();
      t_run();
      t_boost();
      t_idle();
      t_fault();
      t_hold();
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
